/* File: verilog/processor_hot_threshold_config.sv */
// Processor-hot threshold configuration register with alert deglitch filters and gating
`timescale 1ns/1ns
`default_nettype none
`include "processor_hot_alert_params.svh"

module processor_hot_threshold_config #(
  parameter int unsigned CRIT0_CYC = `PHT_CRIT0_CYC,
  parameter int unsigned CRIT1_CYC = `PHT_CRIT1_CYC,
  parameter int unsigned CRIT2_CYC = `PHT_CRIT2_CYC,
  parameter int unsigned CRIT3_CYC = `PHT_CRIT3_CYC,
  parameter int unsigned NOM0_CYC  = `PHT_NOM0_CYC,
  parameter int unsigned NOM1_CYC  = `PHT_NOM1_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Cell-count strap, high for single cell
  input  wire logic        i_single_cell,
  // SMBus word transactions from the protocol engine
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic        i_wr_en,
  input  wire logic [15:0] i_wr_word,
  input  wire logic        i_rd_en,
  output logic [15:0]      o_rd_word,
  output logic             o_rd_valid,
  // Analog comparator levels, asynchronous
  input  wire logic        i_sys_rail_below,
  input  wire logic        i_critical_current_above,
  input  wire logic        i_nominal_current_above,
  input  wire logic        i_input_voltage_below,
  // Profile enables: 0 rail, 1 critical, 2 nominal, 3 input voltage
  input  wire logic [3:0]  i_profile_enable,
  // Decoded thresholds for the analog comparators
  output logic [15:0]      o_sys_rail_threshold_mv,
  output logic [9:0]       o_second_limit_pct,
  output logic [9:0]       o_critical_limit_pct,
  output logic [6:0]       o_nominal_limit_pct,
  output logic [6:0]       o_input_voltage_pct,
  // Alert outputs
  output logic [3:0]       o_event_status,
  output logic             o_sys_rail_uv_event,
  output logic             o_processor_hot_alert_n
);

  // ***************************************************************
  // State
  // ***************************************************************
  processor_hot_alert_pkg::cfg_state_t s_q;
  processor_hot_alert_pkg::cfg_state_t s_d;

  logic sys_held;
  logic crit_held;
  logic nom_held;

  localparam logic [`PHT_CNT_W-1:0] SYS_LIMIT =
    `PHT_CNT_W'(`PHT_SYS_DEG_CYC);

  // ***************************************************************
  // Deglitch filters
  // ***************************************************************
  event_deglitch u_sys_filter (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (s_q.sys_sync[1]),
    .i_limit   (SYS_LIMIT),
    .o_held    (sys_held)
  );

  event_deglitch u_crit_filter (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (s_q.crit_sync[1]),
    .i_limit   (s_q.crit_limit),
    .o_held    (crit_held)
  );

  event_deglitch u_nom_filter (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (s_q.nom_sync[1]),
    .i_limit   (s_q.nom_limit),
    .o_held    (nom_held)
  );

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    logic [5:0]  sys_code;
    logic [4:0]  ilim_code;
    logic [15:0] crit_tmp;
    logic [3:0]  raw;
    sys_code  = '0;
    ilim_code = '0;
    crit_tmp  = '0;
    raw       = '0;
    s_d       = s_q;

    // Second flop alone reads the first
    s_d.cell_sync = {s_q.cell_sync[0], i_single_cell};
    s_d.sys_sync  = {s_q.sys_sync[0], i_sys_rail_below};
    s_d.crit_sync = {s_q.crit_sync[0], i_critical_current_above};
    s_d.nom_sync  = {s_q.nom_sync[0], i_nominal_current_above};
    s_d.vin_sync  = {s_q.vin_sync[0], i_input_voltage_below};

    // Register access
    s_d.rd_valid = 1'b0;
    if (i_cmd_code == `PHT_CMD_CODE) begin
      if (i_wr_en) begin
        s_d.reg_value = i_wr_word;
      end
      if (i_rd_en) begin
        s_d.rd_word  = s_q.reg_value;
        s_d.rd_valid = 1'b1;
      end
    end

    // Rail threshold: stored value kept, decode masked in single cell
    sys_code = s_q.reg_value[`PHT_SYS_MSB:`PHT_SYS_LSB];
    if (s_q.cell_sync[1]) begin
      sys_code[5:3] = 3'b000;
    end
    s_d.sys_mv = `PHT_SYS_OFFSET_MV
               + 16'(sys_code) * `PHT_SYS_STEP_MV;

    // Second limit; invalid codes leave the last level in force
    ilim_code = s_q.reg_value[`PHT_ILIM2_MSB:`PHT_ILIM2_LSB];
    if (ilim_code >= `PHT_ILIM2_CODE_MIN
        && ilim_code < `PHT_ILIM2_CODE_HI) begin
      s_d.second_pct = `PHT_ILIM2_BASE_PCT
        + 10'(ilim_code - `PHT_ILIM2_CODE_MIN)
        * `PHT_ILIM2_STEP_PCT;
    end else if (ilim_code >= `PHT_ILIM2_CODE_HI
                 && ilim_code <= `PHT_ILIM2_CODE_MAX) begin
      s_d.second_pct = `PHT_ILIM2_HI_PCT
        + 10'(ilim_code - `PHT_ILIM2_CODE_HI)
        * `PHT_ILIM2_HI_STEP;
    end
    // Code 31 and 0 fall through: ignored

    crit_tmp = 16'(s_q.second_pct) * `PHT_CRIT_RATIO_PCT / 16'h0064;
    s_d.crit_pct = crit_tmp[9:0];

    case (s_q.reg_value[`PHT_CRIT_MSB:`PHT_CRIT_LSB])
      2'b00:   s_d.crit_limit = `PHT_CNT_W'(CRIT0_CYC);
      2'b01:   s_d.crit_limit = `PHT_CNT_W'(CRIT1_CYC);
      2'b10:   s_d.crit_limit = `PHT_CNT_W'(CRIT2_CYC);
      2'b11:   s_d.crit_limit = `PHT_CNT_W'(CRIT3_CYC);
      default: s_d.crit_limit = `PHT_CNT_W'(CRIT1_CYC);
    endcase

    if (s_q.reg_value[`PHT_NOM_BIT]) begin
      s_d.nom_limit = `PHT_CNT_W'(NOM1_CYC);
    end else begin
      s_d.nom_limit = `PHT_CNT_W'(NOM0_CYC);
    end

    // Input voltage alert threshold
    if (!s_q.reg_value[`PHT_REDUCED_BIT]) begin
      s_d.vin_pct = `PHT_VIN_FULL_PCT;
    end else if (s_q.reg_value[`PHT_RATIO_BIT]) begin
      s_d.vin_pct = `PHT_VIN_HIGH_PCT;
    end else begin
      s_d.vin_pct = `PHT_VIN_LOW_PCT;
    end

    // Event gating onto status and alert pin
    raw          = {s_q.vin_sync[1], nom_held, crit_held, sys_held};
    s_d.events   = raw;
    s_d.reported = raw & i_profile_enable;
    s_d.alert_n  = ~|(raw & i_profile_enable);

    // Synchronous reset; strap sampled through its synchroniser
    if (i_sys_rst) begin
      if (s_q.cell_sync[1]) begin
        s_d.reg_value = `PHT_RST_SINGLE;
      end else begin
        s_d.reg_value = `PHT_RST_MULTI;
      end
      s_d.second_pct = `PHT_ILIM2_RST_PCT;
      s_d.rd_word    = '0;
      s_d.rd_valid   = 1'b0;
      s_d.events     = '0;
      s_d.reported   = '0;
      s_d.alert_n    = 1'b1;
      s_d.sys_sync   = '0;
      s_d.crit_sync  = '0;
      s_d.nom_sync   = '0;
      s_d.vin_sync   = '0;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    s_q <= s_d;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign o_rd_word               = s_q.rd_word;
  assign o_rd_valid              = s_q.rd_valid;
  assign o_sys_rail_threshold_mv = s_q.sys_mv;
  assign o_second_limit_pct      = s_q.second_pct;
  assign o_critical_limit_pct    = s_q.crit_pct;
  assign o_input_voltage_pct     = s_q.vin_pct;
  assign o_event_status          = s_q.reported;
  assign o_sys_rail_uv_event     = s_q.events[0];
  assign o_processor_hot_alert_n = s_q.alert_n;

  // Fixed ratio, held in a flop so the port is registered
  logic [6:0] nom_pct_q;
  always_ff @(posedge i_clk) begin
    nom_pct_q <= `PHT_NOM_RATIO_PCT;
  end
  assign o_nominal_limit_pct = nom_pct_q;

endmodule : processor_hot_threshold_config
`default_nettype wire

/* File: verilog/processor_hot_alert_params.svh */
// Constants for the processor-hot threshold configuration register
`ifndef PROCESSOR_HOT_ALERT_PARAMS_SVH
`define PROCESSOR_HOT_ALERT_PARAMS_SVH

// ***************************************************************
// Register location and reset images
// ***************************************************************
`define PHT_CMD_CODE        8'h33
`define PHT_RST_MULTI       16'h4A81
`define PHT_RST_SINGLE      16'h4A09

// ***************************************************************
// Field positions
// ***************************************************************
`define PHT_ILIM2_MSB       15
`define PHT_ILIM2_LSB       11
`define PHT_CRIT_MSB        10
`define PHT_CRIT_LSB        9
`define PHT_RATIO_BIT       8
`define PHT_SYS_MSB         7
`define PHT_SYS_LSB         2
`define PHT_SYS_1S_MSB      4
`define PHT_NOM_BIT         1
`define PHT_REDUCED_BIT     0

// ***************************************************************
// Decode constants
// ***************************************************************
`define PHT_SYS_OFFSET_MV   16'h0C80
`define PHT_SYS_STEP_MV     16'h0064
`define PHT_ILIM2_CODE_MIN  5'h01
`define PHT_ILIM2_CODE_HI   5'h1A
`define PHT_ILIM2_CODE_MAX  5'h1E
`define PHT_ILIM2_BASE_PCT  10'h06E
`define PHT_ILIM2_STEP_PCT  10'h005
`define PHT_ILIM2_HI_PCT    10'h0FA
`define PHT_ILIM2_HI_STEP   10'h032
`define PHT_ILIM2_RST_PCT   10'h096
`define PHT_CRIT_RATIO_PCT  16'h006E
`define PHT_NOM_RATIO_PCT   7'h6E
`define PHT_VIN_FULL_PCT    7'h64
`define PHT_VIN_LOW_PCT     7'h53
`define PHT_VIN_HIGH_PCT    7'h5B

// ***************************************************************
// Timing
// ***************************************************************
`define PHT_CLK_MHZ         50
`define PHT_CNT_W           22
`define PHT_SYS_DEG_US      5
`define PHT_CRIT0_US        15
`define PHT_CRIT1_US        100
`define PHT_CRIT2_US        400
`define PHT_CRIT3_US        800
`define PHT_NOM0_MS         1
`define PHT_NOM1_MS         60
`define PHT_SYS_DEG_CYC     (`PHT_SYS_DEG_US * `PHT_CLK_MHZ)
`define PHT_CRIT0_CYC       (`PHT_CRIT0_US * `PHT_CLK_MHZ)
`define PHT_CRIT1_CYC       (`PHT_CRIT1_US * `PHT_CLK_MHZ)
`define PHT_CRIT2_CYC       (`PHT_CRIT2_US * `PHT_CLK_MHZ)
`define PHT_CRIT3_CYC       (`PHT_CRIT3_US * `PHT_CLK_MHZ)
`define PHT_NOM0_CYC        (`PHT_NOM0_MS * 1000 * `PHT_CLK_MHZ)
`define PHT_NOM1_CYC        (`PHT_NOM1_MS * 1000 * `PHT_CLK_MHZ)

`endif

/* File: verilog/processor_hot_alert_pkg.sv */
// Types for the processor-hot threshold configuration block
`include "processor_hot_alert_params.svh"

package processor_hot_alert_pkg;

  // ***************************************************************
  // Deglitch filter state
  // ***************************************************************
  typedef struct packed {
    logic [`PHT_CNT_W-1:0] cnt;
    logic                  held;
  } filt_state_t;

  // ***************************************************************
  // Register block state
  // ***************************************************************
  typedef struct packed {
    logic [1:0]            cell_sync;
    logic [1:0]            sys_sync;
    logic [1:0]            crit_sync;
    logic [1:0]            nom_sync;
    logic [1:0]            vin_sync;
    logic [15:0]           reg_value;
    logic [9:0]            second_pct;
    logic [9:0]            crit_pct;
    logic [15:0]           sys_mv;
    logic [6:0]            vin_pct;
    logic [`PHT_CNT_W-1:0] crit_limit;
    logic [`PHT_CNT_W-1:0] nom_limit;
    logic [15:0]           rd_word;
    logic                  rd_valid;
    logic [3:0]            events;
    logic [3:0]            reported;
    logic                  alert_n;
  } cfg_state_t;

endpackage : processor_hot_alert_pkg

/* File: verilog/event_deglitch.sv */
// Deglitch filter: output rises once input held high for a set count
`timescale 1ns/1ns
`default_nettype none
`include "processor_hot_alert_params.svh"

module event_deglitch (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // Level to filter and hold time in cycles
  input  wire logic                  i_level,
  input  wire logic [`PHT_CNT_W-1:0] i_limit,
  // Filtered level
  output logic                       o_held
);

  processor_hot_alert_pkg::filt_state_t s_q;
  processor_hot_alert_pkg::filt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!i_level) begin
      // Any dropout restarts the hold time
      s_d.cnt  = '0;
      s_d.held = 1'b0;
    end else begin
      if (s_q.cnt < i_limit) begin
        s_d.cnt = s_q.cnt + `PHT_CNT_W'(1);
      end
      s_d.held = (s_q.cnt + `PHT_CNT_W'(1)) >= i_limit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_held = s_q.held;

endmodule : event_deglitch
`default_nettype wire

/* File: testbench/processor_hot_alert_properties.sv */
// Checker for the processor-hot threshold configuration block
`timescale 1ns/1ns
`default_nettype none

module processor_hot_alert_checker (
  // Clock, reset and inputs
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_single_cell,
  input wire logic [7:0]  i_cmd_code,
  input wire logic        i_rd_en,
  input wire logic        i_sys_rail_below,
  input wire logic [3:0]  i_profile_enable,
  // Observed outputs
  input wire logic        o_rd_valid,
  input wire logic [15:0] o_sys_rail_threshold_mv,
  input wire logic [9:0]  o_second_limit_pct,
  input wire logic [9:0]  o_critical_limit_pct,
  input wire logic [6:0]  o_nominal_limit_pct,
  input wire logic [6:0]  o_input_voltage_pct,
  input wire logic [3:0]  o_event_status,
  input wire logic        o_sys_rail_uv_event,
  input wire logic        o_processor_hot_alert_n
);
  // ****
  // Rail-low run length, saturating so long holds never wrap
  // ****
  logic [8:0] run_q, run_d;
  always_comb run_d = (i_sys_rst || !i_sys_rail_below) ? 9'h000
                      : run_q + {8'h00, run_q != 9'h1FF};
  always_ff @(posedge i_clk) run_q <= run_d;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_rd_ans;
    i_rd_en && i_cmd_code == 8'h33 |=> o_rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_rd_ref;
    !(i_rd_en && i_cmd_code == 8'h33) |=> !o_rd_valid; endproperty
  a_rd_ref: assert property (p_rd_ref) else $error("stray read");
  property p_nom;
    o_nominal_limit_pct == 7'h6E; endproperty
  a_nom: assert property (p_nom) else $error("nominal level");
  property p_step;
    o_sys_rail_threshold_mv >= 16'h0C80 && o_sys_rail_threshold_mv <= 16'h251C
    && (o_sys_rail_threshold_mv - 16'h0C80) % 16'h0064 == 16'h0000; endproperty
  a_step: assert property (p_step) else $error("rail step");
  property p_one;
    i_single_cell && $stable(i_single_cell)
    |-> o_sys_rail_threshold_mv <= 16'h0F3C; endproperty
  a_one: assert property (p_one) else $error("single cell max");
  property p_crit;
    $stable(o_second_limit_pct) |-> {10'h000, o_critical_limit_pct} ==
    ({10'h000, o_second_limit_pct} * 20'h0_006E) / 20'h0_0064; endproperty
  a_crit: assert property (p_crit) else $error("critical ratio");
  property p_vin;
    o_input_voltage_pct inside {7'h64, 7'h53, 7'h5B}; endproperty
  a_vin: assert property (p_vin) else $error("input ratio");
  property p_gate;
    $stable(i_profile_enable)
    |-> (o_event_status & ~i_profile_enable) == 4'h0; endproperty
  a_gate: assert property (p_gate) else $error("ungated status");
  property p_alert;
    $stable(o_event_status)
    |-> o_processor_hot_alert_n == ~|o_event_status; endproperty
  a_alert: assert property (p_alert) else $error("alert level");
  property p_rail;
    $rose(o_sys_rail_uv_event) |-> run_q >= 9'h0FA && run_q <= 9'h100;
  endproperty
  a_rail: assert property (p_rail) else $error("rail filter");
endmodule : processor_hot_alert_checker

bind processor_hot_threshold_config processor_hot_alert_checker i_processor_hot_alert_checker (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_single_cell(i_single_cell),
  .i_cmd_code(i_cmd_code), .i_rd_en(i_rd_en),
  .i_sys_rail_below(i_sys_rail_below), .i_profile_enable(i_profile_enable),
  .o_rd_valid(o_rd_valid), .o_sys_rail_threshold_mv(o_sys_rail_threshold_mv),
  .o_second_limit_pct(o_second_limit_pct),
  .o_critical_limit_pct(o_critical_limit_pct),
  .o_nominal_limit_pct(o_nominal_limit_pct),
  .o_input_voltage_pct(o_input_voltage_pct), .o_event_status(o_event_status),
  .o_sys_rail_uv_event(o_sys_rail_uv_event),
  .o_processor_hot_alert_n(o_processor_hot_alert_n)
);
`default_nettype wire

/* File: testbench/smbus_host_model.sv */
// Host stand-in issuing decoded word writes and reads
`timescale 1ns/1ns
`default_nettype none

module smbus_host_model (
  // Clock
  input  wire logic   i_clk,
  // Word transaction requests
  output logic [7:0]  o_cmd_code,
  output logic        o_wr_en,
  output logic [15:0] o_wr_word,
  output logic        o_rd_en
);
  initial begin
    o_cmd_code = 8'h00;
    o_wr_en    = 1'b0;
    o_wr_word  = 16'h0000;
    o_rd_en    = 1'b0;
  end
  // Data inverted once released so a stale word is never reused
  task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
    @(negedge i_clk);
    o_cmd_code = cmd;
    o_wr_en    = 1'b1;
    o_wr_word  = w;
    @(negedge i_clk);
    o_wr_en    = 1'b0;
    o_wr_word  = ~w;
  endtask : wr
  task automatic rd(input logic [7:0] cmd);
    @(negedge i_clk);
    o_cmd_code = cmd;
    o_rd_en    = 1'b1;
    @(negedge i_clk);
    o_rd_en    = 1'b0;
  endtask : rd
endmodule : smbus_host_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the processor-hot threshold configuration block
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        clk = 1'b0, rst = 1'b1, one = 1'b0, wr, rde, rdv, uv, aln;
  logic [7:0]  cmd;
  logic [15:0] wdat, rdw, mv, w;
  logic [9:0]  sec, crit;
  logic [6:0]  nom, vin;
  logic [3:0]  below = 4'h0, pen = 4'h0, st;
  logic [15:0] expq[$];
  logic [15:0] fixed[4] = '{16'hF800, 16'h0001, 16'hD7FC, 16'hC903};
  int          miscompares = 0, n_compared = 0, pct = 150;
  integer      seed = 32'h79089f25;

  always #10 clk = ~clk;

  smbus_host_model i_smbus_host_model (.i_clk(clk), .o_cmd_code(cmd),
    .o_wr_en(wr), .o_wr_word(wdat), .o_rd_en(rde));
  processor_hot_threshold_config #(.CRIT0_CYC(4), .CRIT1_CYC(8),
    .CRIT2_CYC(12), .CRIT3_CYC(16), .NOM0_CYC(20), .NOM1_CYC(40))
  i_processor_hot_threshold_config (.i_clk(clk), .i_sys_rst(rst),
    .i_single_cell(one), .i_cmd_code(cmd), .i_wr_en(wr), .i_wr_word(wdat),
    .i_rd_en(rde), .o_rd_word(rdw), .o_rd_valid(rdv),
    .i_sys_rail_below(below[0]), .i_critical_current_above(below[1]),
    .i_nominal_current_above(below[2]), .i_input_voltage_below(below[3]),
    .i_profile_enable(pen), .o_sys_rail_threshold_mv(mv),
    .o_second_limit_pct(sec), .o_critical_limit_pct(crit),
    .o_nominal_limit_pct(nom), .o_input_voltage_pct(vin),
    .o_event_status(st), .o_sys_rail_uv_event(uv),
    .o_processor_hot_alert_n(aln));

  task automatic chk(input string nm, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic give_verdict;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Read answers are matched oldest first against the noted words
  always @(negedge clk) begin
    if (rdv === 1'b1) begin
      if (expq.size() == 0) chk("rd_valid", 0, 1);
      else chk("rd_word", expq.pop_front(), rdw);
    end
  end

  task automatic do_reset(input logic single);
    @(negedge clk);
    rst = 1'b1;
    one = single;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    pct = 150;
    expq.push_back(single ? 16'h4A09 : 16'h4A81);
    i_smbus_host_model.rd(8'h33);
    repeat (2) @(negedge clk);
    chk("rail_mv", single ? 3400 : 6400, mv);
    chk("second", 150, sec);
    chk("vin", 83, vin);
  endtask : do_reset

  task automatic apply(input logic [15:0] v);
    logic [4:0] c;
    logic [5:0] t;
    c = v[15:11];
    t = one ? {3'b000, v[4:2]} : v[7:2];
    i_smbus_host_model.wr(8'h33, v);
    expq.push_back(v);
    i_smbus_host_model.rd(8'h33);
    repeat (2) @(negedge clk);
    if (c != 0 && c != 31) pct = c < 26 ? 105 + 5 * c : 250 + 50 * (c - 26);
    chk("second", pct, sec);
    chk("crit", pct * 110 / 100, crit);
    chk("rail_mv", 3200 + 100 * t, mv);
    chk("vin", !v[0] ? 100 : (v[8] ? 91 : 83), vin);
    chk("nom", 110, nom);
  endtask : apply

  // Event on input b with filter n; disabled profile must stay silent
  task automatic evt(input int b, n, input logic en);
    int k;
    k = 0;
    // Other profile bits random: their events stay idle, so their status bits stay clear without any gating
    pen = 4'($random(seed));
    pen[b] = en;
    below[b] = 1'b1;
    while (st[b] !== 1'b1 && k < n + 40) begin
      @(negedge clk);
      k++;
    end
    if (en) begin
      chk("delay", 1, k >= n + 1 && k <= n + 6);
      chk("alert_n", 0, aln);
      if (k >= n + 40) give_verdict;
    end else begin
      chk("status", 0, st);
      chk("alert_n", 1, aln);
    end
    if (b == 0) chk("uv", 1, uv);
    below[b] = 1'b0;
    pen = 4'h0;
    repeat (8) @(negedge clk);
  endtask : evt

  initial begin
    do_reset(1'b0);
    for (int i = 0; i < 40; i++) begin
      w = i < 4 ? fixed[i] : 16'($random(seed));
      apply(w);
    end
    i_smbus_host_model.wr(8'h34, 16'h0000);
    expq.push_back(w);
    i_smbus_host_model.rd(8'h34);
    i_smbus_host_model.rd(8'h33);
    for (int c = 0; c < 4; c++) begin
      apply({5'h09, c[1:0], 9'h001});
      evt(1, 4 * (c + 1), 1'b1);
    end
    evt(1, 16, 1'b0);
    evt(2, 20, 1'b1);
    apply(16'h4A83);
    evt(2, 40, 1'b1);
    evt(0, 250, 1'b1);
    evt(0, 250, 1'b0);
    evt(3, 0, 1'b1);
    do_reset(1'b1);
    for (int i = 0; i < 12; i++) apply(16'($random(seed)));
    repeat (4) @(negedge clk);
    chk("pending", 0, expq.size());
    give_verdict;
  end
endmodule : tb
`default_nettype wire
